// ===== hdl/rmc_consts.svh
// Constants of the radio module mode and configuration link
`ifndef RMC_CONSTS_SVH
`define RMC_CONSTS_SVH
`define RMC_CLK_HZ 20000000
`define RMC_CLK_MHZ 20
`define RMC_CFG_BAUD 9600
`define RMC_HDR_SAVE 8'hC0
`define RMC_HDR_READ 8'hC1
`define RMC_HDR_VOLATILE 8'hC2
`define RMC_HDR_VERSION 8'hC3
`define RMC_HDR_RESET 8'hC4
`define RMC_DEF_ADDH 8'h00
`define RMC_DEF_ADDL 8'h00
`define RMC_DEF_SPEED 8'h18
`define RMC_DEF_CHAN 8'h44
`define RMC_DEF_OPTION 8'h1C
`define RMC_PARAM_BYTES 5
`define RMC_IDX_SPEED 2
`define RMC_IDX_OPTION 4
`define RMC_BAUD_MSB 5
`define RMC_BAUD_LSB 3
`define RMC_WAKE_MSB 5
`define RMC_WAKE_LSB 3
`define RMC_WAKE_UNIT 8'h10
`define RMC_VERSION_LEN 4
`define RMC_READ_LEN 6
`define RMC_RECONF_US 1000
`define RMC_GAP_BITS 20
`define RMC_WOR_PERIOD_US 1000000
`define RMC_LISTEN_US 2000
`define RMC_ADDR_CTRL 8'h00
`define RMC_ADDR_TXDATA 8'h04
`define RMC_ADDR_RXDATA 8'h08
`define RMC_ADDR_STATUS 8'h0C
`define RMC_ADDR_MASK 8'h10
`define RMC_ST_RX 0
`define RMC_ST_TXDONE 1
`define RMC_ST_READY 2
`define RMC_ST_READY_LVL 8
`define RMC_ST_TXBUSY 9
`endif

// ===== hdl/rmc_pkg.sv
// Types and shared functions of the radio module mode and configuration link
`include "rmc_consts.svh"
package rmc_pkg;
  typedef enum logic [2:0] {
    RMC_MODE_RSSI = 3'b000,
    RMC_MODE_CONT = 3'b001,
    RMC_MODE_SUBPKT = 3'b010,
    RMC_MODE_CFG3 = 3'b011,
    RMC_MODE_WAKE = 3'b100,
    RMC_MODE_CFG5 = 3'b101,
    RMC_MODE_SAVE = 3'b110,
    RMC_MODE_SLEEP = 3'b111
  } rmc_mode_t;
  typedef enum logic [1:0] {
    RMC_P_IDLE = 2'b00,
    RMC_P_PARAM = 2'b01,
    RMC_P_TRIPLE = 2'b10
  } rmc_parse_t;
  // Bit period in clocks for a speed code
  function automatic logic [15:0] rmc_baud_div(input logic [2:0] code);
    case (code)
      3'd0: rmc_baud_div = 16'(`RMC_CLK_HZ / 1200);
      3'd1: rmc_baud_div = 16'(`RMC_CLK_HZ / 2400);
      3'd2: rmc_baud_div = 16'(`RMC_CLK_HZ / 4800);
      3'd3: rmc_baud_div = 16'(`RMC_CLK_HZ / 9600);
      3'd4: rmc_baud_div = 16'(`RMC_CLK_HZ / 19200);
      3'd5: rmc_baud_div = 16'(`RMC_CLK_HZ / 38400);
      3'd6: rmc_baud_div = 16'(`RMC_CLK_HZ / 57600);
      default: rmc_baud_div = 16'(`RMC_CLK_HZ / 115200);
    endcase
  endfunction
  function automatic logic rmc_is_cfg(input logic [2:0] m);
    rmc_is_cfg = (m == RMC_MODE_CFG3) || (m == RMC_MODE_CFG5);
  endfunction
endpackage

// ===== hdl/rmc_link_if.sv
// Pin-level link between host controller and radio module
`timescale 1ns/1ps
`default_nettype none
interface rmc_link_if;
  logic mode_select_0;
  logic mode_select_1;
  logic mode_select_2;
  logic host_txd;
  logic dev_txd;
  logic ready_status;
  modport dev (input mode_select_0, mode_select_1, mode_select_2, host_txd,
    output dev_txd, ready_status);
  modport host (output mode_select_0, mode_select_1, mode_select_2, host_txd,
    input dev_txd, ready_status);
endinterface
`default_nettype wire

// ===== hdl/rmc_uart.sv
// Byte UART, 8N1, run-time bit period
`timescale 1ns/1ps
`default_nettype none
module rmc_uart (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] div_i,
  input wire logic rxd_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_start_i,
  output logic txd_o,
  output logic tx_busy_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o
);
  logic rxd_s1_reg, rxd_s2_reg, rx_act_reg;
  logic [15:0] rx_cnt_reg, tx_cnt_reg;
  logic [3:0] rx_bit_reg, tx_bits_reg;
  logic [7:0] rx_sh_reg;
  logic [8:0] tx_sh_reg;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
    end else begin
      rxd_s1_reg <= rxd_i;
      rxd_s2_reg <= rxd_s1_reg;
    end
  end
  // Sample mid-bit; a start glitch shorter than half a bit is dropped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_act_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (!rx_act_reg) begin
        if (!rxd_s2_reg) begin
          rx_act_reg <= 1'b1;
          rx_cnt_reg <= div_i >> 1;
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg == 16'h0000) begin
        rx_cnt_reg <= div_i - 16'h0001;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0) begin
          if (rxd_s2_reg) rx_act_reg <= 1'b0;
        end else if (rx_bit_reg < 4'h9) begin
          rx_sh_reg <= {rxd_s2_reg, rx_sh_reg[7:1]};
        end else begin
          rx_act_reg <= 1'b0;
          rx_valid_o <= rxd_s2_reg;
          rx_data_o <= rx_sh_reg;
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      txd_o <= 1'b1;
      tx_busy_o <= 1'b0;
      tx_sh_reg <= 9'h1FF;
      tx_cnt_reg <= 16'h0000;
      tx_bits_reg <= 4'h0;
    end else if (!tx_busy_o) begin
      if (tx_start_i) begin
        txd_o <= 1'b0;
        tx_busy_o <= 1'b1;
        tx_sh_reg <= {1'b1, tx_data_i};
        tx_bits_reg <= 4'h9;
        tx_cnt_reg <= div_i - 16'h0001;
      end
    end else if (tx_cnt_reg != 16'h0000) begin
      tx_cnt_reg <= tx_cnt_reg - 16'h0001;
    end else if (tx_bits_reg == 4'h0) begin
      tx_busy_o <= 1'b0;
    end else begin
      txd_o <= tx_sh_reg[0];
      tx_sh_reg <= {1'b1, tx_sh_reg[8:1]};
      tx_bits_reg <= tx_bits_reg - 4'h1;
      tx_cnt_reg <= div_i - 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/rmc_dev.sv
// Radio module end: mode pins, configuration commands, ready output
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Mode 5 disables radio, bytes are commands
// - Configuration traffic always 9600 baud 8N1
// - Leaving configuration reapplies params, ready low
// - Host waits for ready rise after switching
// - Power saving mode refuses transmit, keeps receive
// - Power saving wakes periodically, forwards packets
// - Power saving accepts only wake-up mode packets
// - All pins high shuts everything down
// - Mode 3 accepts the configuration instruction set
// - C0 plus five bytes saved non-volatile
// - C2 plus five bytes applied, not saved
// - Three C1 reply six-byte parameter frame
// - Three C3 return version information
// - Three C4 reset module exactly once
// - Factory default frame C0 00 00 18 44 1C
// - Speed byte bits 5..3 select baud
// - Wake-up transmit prepends code scaled by time
module rmc_dev
  import rmc_pkg::*;
#(
  parameter int unsigned RECONF_CYC = `RMC_RECONF_US * `RMC_CLK_MHZ,
  parameter int unsigned GAP_CYC = `RMC_GAP_BITS * (`RMC_CLK_HZ / `RMC_CFG_BAUD),
  parameter int unsigned WOR_CYC = `RMC_WOR_PERIOD_US * `RMC_CLK_MHZ,
  parameter int unsigned LISTEN_CYC = `RMC_LISTEN_US * `RMC_CLK_MHZ,
  // Arbitrary identification values
  parameter logic [7:0] VER_MODEL = 8'h5A,
  parameter logic [7:0] VER_NUM = 8'h01,
  parameter logic [7:0] VER_FEAT = 8'h00
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  rmc_link_if.dev LINK,
  input wire logic [7:0] RF_BYTE_I,
  input wire logic RF_BYTE_VALID_I,
  input wire logic RF_PKT_WAKE_I,
  input wire logic RF_PKT_END_I,
  output logic RF_TX_EN_O,
  output logic RF_RX_EN_O,
  output logic WOR_LISTEN_O,
  output logic [7:0] RF_TX_DATA_O,
  output logic RF_TX_VALID_O,
  output logic [7:0] WAKE_CODE_LEN_O,
  output logic NV_WRITE_O,
  output logic [2:0] MODE_O
);
  logic [2:0] pin_s1_reg, pin_s2_reg;
  logic [2:0] mode_reg;
  logic [31:0] busy_cnt_reg, gap_cnt_reg, wor_cnt_reg, listen_cnt_reg;
  logic ready_reg, was_cfg_reg, pkt_act_reg;
  logic [7:0] work_reg [`RMC_PARAM_BYTES];
  logic [7:0] nv_reg [`RMC_PARAM_BYTES];
  logic [7:0] shadow_reg [`RMC_PARAM_BYTES];
  rmc_parse_t parse_reg;
  logic [7:0] hdr_reg;
  logic [2:0] cnt_reg;
  logic [7:0] rep_kind_reg;
  logic [2:0] rep_idx_reg, rep_len_reg;
  logic tx_start_reg;
  logic [7:0] tx_data_reg;
  logic [15:0] div;
  logic tx_busy, rx_valid;
  logic [7:0] rx_data;
  logic cfg, busy, cmd_ok, fwd_rf;

  function automatic logic [7:0] reply_byte(input logic [7:0] kind, input logic [2:0] idx,
      input logic [7:0] p0, input logic [7:0] p1, input logic [7:0] p2,
      input logic [7:0] p3, input logic [7:0] p4);
    case (idx)
      3'd0: reply_byte = (kind == `RMC_HDR_READ) ? `RMC_HDR_SAVE : `RMC_HDR_VERSION;
      3'd1: reply_byte = (kind == `RMC_HDR_READ) ? p0 : VER_MODEL;
      3'd2: reply_byte = (kind == `RMC_HDR_READ) ? p1 : VER_NUM;
      3'd3: reply_byte = (kind == `RMC_HDR_READ) ? p2 : VER_FEAT;
      3'd4: reply_byte = p3;
      default: reply_byte = p4;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // fixed 9600 while configuring
  assign div = rmc_is_cfg(mode_reg) ? rmc_baud_div(3'd3)
    : rmc_baud_div(work_reg[`RMC_IDX_SPEED][`RMC_BAUD_MSB:`RMC_BAUD_LSB]);
  assign cfg = rmc_is_cfg(mode_reg);
  assign busy = (busy_cnt_reg != 32'h0000_0000);
  assign cmd_ok = rx_valid && cfg && !busy;

  rmc_uart u_uart (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .div_i(div),
    .rxd_i(LINK.host_txd),
    .tx_data_i(tx_data_reg),
    .tx_start_i(tx_start_reg),
    .txd_o(LINK.dev_txd),
    .tx_busy_o(tx_busy),
    .rx_data_o(rx_data),
    .rx_valid_o(rx_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // pins sampled continuously
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1_reg <= RMC_MODE_SLEEP;
      pin_s2_reg <= RMC_MODE_SLEEP;
    end else begin
      pin_s1_reg <= {LINK.mode_select_2, LINK.mode_select_1, LINK.mode_select_0};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Power-up counts as a reconfiguration, so ready starts low
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_reg <= RMC_MODE_SLEEP;
      was_cfg_reg <= 1'b0;
      busy_cnt_reg <= 32'(RECONF_CYC);
      ready_reg <= 1'b0;
    end else begin
      was_cfg_reg <= cfg;
      if (pin_s2_reg != mode_reg) begin
        mode_reg <= pin_s2_reg;
        busy_cnt_reg <= 32'(RECONF_CYC);
      end else if (cmd_ok && parse_reg == RMC_P_TRIPLE && rx_data == hdr_reg
          && cnt_reg == 3'd2 && hdr_reg == `RMC_HDR_RESET) begin
        busy_cnt_reg <= 32'(RECONF_CYC);
      end else if (busy) begin
        busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
      end
      // low through reapply, high once done
      ready_reg <= !busy && (pin_s2_reg == mode_reg);
    end
  end
  assign LINK.ready_status = ready_reg;

  ////////////////////////////////////////////////////////////////////////
  // commands only in configuration modes
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      parse_reg <= RMC_P_IDLE;
      hdr_reg <= 8'h00;
      cnt_reg <= 3'd0;
      gap_cnt_reg <= 32'h0000_0000;
    end else if (!cfg) begin
      parse_reg <= RMC_P_IDLE;
    end else if (cmd_ok) begin
      gap_cnt_reg <= 32'(GAP_CYC);
      case (parse_reg)
        RMC_P_IDLE: begin
          hdr_reg <= rx_data;
          cnt_reg <= 3'd1;
          if (rx_data == `RMC_HDR_SAVE || rx_data == `RMC_HDR_VOLATILE) begin
            cnt_reg <= 3'd0;
            parse_reg <= RMC_P_PARAM;
          end else if (rx_data == `RMC_HDR_READ || rx_data == `RMC_HDR_VERSION
              || rx_data == `RMC_HDR_RESET) begin
            parse_reg <= RMC_P_TRIPLE;
          end
        end
        RMC_P_PARAM: begin
          cnt_reg <= cnt_reg + 3'd1;
          if (cnt_reg == 3'(`RMC_PARAM_BYTES - 1)) parse_reg <= RMC_P_IDLE;
        end
        RMC_P_TRIPLE: begin
          cnt_reg <= cnt_reg + 3'd1;
          if (rx_data != hdr_reg || cnt_reg == 3'd2) parse_reg <= RMC_P_IDLE;
        end
        default: parse_reg <= RMC_P_IDLE;
      endcase
    end else if (parse_reg != RMC_P_IDLE) begin
      if (gap_cnt_reg == 32'h0000_0000) parse_reg <= RMC_P_IDLE;
      else gap_cnt_reg <= gap_cnt_reg - 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up loads factory frame
  // six-byte frame saved to nv copy
  // volatile frame updates working set only
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < `RMC_PARAM_BYTES; i++) begin
        shadow_reg[i] <= 8'h00;
      end
      work_reg[0] <= `RMC_DEF_ADDH;
      work_reg[1] <= `RMC_DEF_ADDL;
      work_reg[2] <= `RMC_DEF_SPEED;
      work_reg[3] <= `RMC_DEF_CHAN;
      work_reg[4] <= `RMC_DEF_OPTION;
      nv_reg[0] <= `RMC_DEF_ADDH;
      nv_reg[1] <= `RMC_DEF_ADDL;
      nv_reg[2] <= `RMC_DEF_SPEED;
      nv_reg[3] <= `RMC_DEF_CHAN;
      nv_reg[4] <= `RMC_DEF_OPTION;
      NV_WRITE_O <= 1'b0;
    end else begin
      NV_WRITE_O <= 1'b0;
      if (cmd_ok && parse_reg == RMC_P_PARAM) begin
        shadow_reg[cnt_reg] <= rx_data;
        if (cnt_reg == 3'(`RMC_PARAM_BYTES - 1)) begin
          for (int i = 0; i < `RMC_PARAM_BYTES - 1; i++) begin
            work_reg[i] <= shadow_reg[i];
            if (hdr_reg == `RMC_HDR_SAVE) nv_reg[i] <= shadow_reg[i];
          end
          work_reg[`RMC_PARAM_BYTES - 1] <= rx_data;
          if (hdr_reg == `RMC_HDR_SAVE) begin
            nv_reg[`RMC_PARAM_BYTES - 1] <= rx_data;
            NV_WRITE_O <= 1'b1;
          end
        end
      end else if (cmd_ok && parse_reg == RMC_P_TRIPLE && rx_data == hdr_reg
          && cnt_reg == 3'd2 && hdr_reg == `RMC_HDR_RESET) begin
        for (int i = 0; i < `RMC_PARAM_BYTES; i++) begin
          work_reg[i] <= nv_reg[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // No buffer: a radio byte arriving while the UART is busy is lost
  assign fwd_rf = RF_BYTE_VALID_I && RF_RX_EN_O && !tx_busy && !tx_start_reg
    && (mode_reg != RMC_MODE_SAVE || RF_PKT_WAKE_I);
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rep_kind_reg <= 8'h00;
      rep_idx_reg <= 3'd0;
      rep_len_reg <= 3'd0;
      tx_start_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else begin
      tx_start_reg <= 1'b0;
      if (cmd_ok && parse_reg == RMC_P_TRIPLE && rx_data == hdr_reg && cnt_reg == 3'd2
          && hdr_reg != `RMC_HDR_RESET) begin
        rep_kind_reg <= hdr_reg;
        rep_idx_reg <= 3'd0;
        rep_len_reg <= (hdr_reg == `RMC_HDR_READ) ? 3'(`RMC_READ_LEN)
          : 3'(`RMC_VERSION_LEN);
      end else if (rep_idx_reg != rep_len_reg && cfg && !tx_busy && !tx_start_reg) begin
        tx_start_reg <= 1'b1;
        tx_data_reg <= reply_byte(rep_kind_reg, rep_idx_reg, work_reg[0], work_reg[1],
          work_reg[2], work_reg[3], work_reg[4]);
        rep_idx_reg <= rep_idx_reg + 3'd1;
      end else if (!cfg) begin
        rep_len_reg <= 3'd0;
        rep_idx_reg <= 3'd0;
        // only wake-up packets in power saving
        if (fwd_rf) begin
          tx_start_reg <= 1'b1;
          tx_data_reg <= RF_BYTE_I;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // periodic wake, listen, back to sleep
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wor_cnt_reg <= 32'h0000_0000;
      listen_cnt_reg <= 32'h0000_0000;
      pkt_act_reg <= 1'b0;
      WOR_LISTEN_O <= 1'b0;
    end else if (mode_reg != RMC_MODE_SAVE || busy) begin
      wor_cnt_reg <= 32'(WOR_CYC);
      listen_cnt_reg <= 32'h0000_0000;
      pkt_act_reg <= 1'b0;
      WOR_LISTEN_O <= 1'b0;
    end else begin
      if (wor_cnt_reg == 32'h0000_0000) begin
        wor_cnt_reg <= 32'(WOR_CYC);
        listen_cnt_reg <= 32'(LISTEN_CYC);
      end else begin
        wor_cnt_reg <= wor_cnt_reg - 32'h0000_0001;
        if (listen_cnt_reg != 32'h0000_0000) begin
          listen_cnt_reg <= listen_cnt_reg - 32'h0000_0001;
        end
      end
      if (RF_PKT_END_I) pkt_act_reg <= 1'b0;
      else if (RF_BYTE_VALID_I && RF_PKT_WAKE_I && WOR_LISTEN_O) pkt_act_reg <= 1'b1;
      WOR_LISTEN_O <= (listen_cnt_reg != 32'h0000_0000) || pkt_act_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      RF_TX_EN_O <= 1'b0;
      RF_RX_EN_O <= 1'b0;
      RF_TX_VALID_O <= 1'b0;
      RF_TX_DATA_O <= 8'h00;
      WAKE_CODE_LEN_O <= 8'h00;
      MODE_O <= RMC_MODE_SLEEP;
    end else begin
      MODE_O <= mode_reg;
      // sleep and configuration stop the radio
      RF_TX_EN_O <= !busy && (mode_reg <= RMC_MODE_WAKE) && !cfg;
      RF_RX_EN_O <= !busy && (mode_reg <= RMC_MODE_SUBPKT || mode_reg == RMC_MODE_SAVE);
      RF_TX_VALID_O <= rx_valid && RF_TX_EN_O;
      RF_TX_DATA_O <= rx_data;
      // wake code length scales with time
      WAKE_CODE_LEN_O <= (mode_reg == RMC_MODE_WAKE) ? 8'(({5'h00,
        work_reg[`RMC_IDX_OPTION][`RMC_WAKE_MSB:`RMC_WAKE_LSB]} + 8'h01) * `RMC_WAKE_UNIT)
        : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/rmc_host.sv
// Host controller end: AHB-Lite registers driving mode pins and UART
`timescale 1ns/1ps
`default_nettype none
module rmc_host
  import rmc_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  rmc_link_if.host LINK,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic IRQ_O
);
  logic [5:0] ctrl_reg;
  logic [2:0] status_reg, mask_reg;
  logic [7:0] rx_reg, tx_data_reg;
  logic tx_start_reg, rdy_s1_reg, rdy_s2_reg, rdy_d_reg, busy_d_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic tx_busy, rx_valid;
  logic [7:0] rx_data;
  logic [2:0] ev;
  logic take;
  logic [15:0] div;

  // host also runs 9600 while configuring
  assign div = rmc_is_cfg(ctrl_reg[2:0]) ? rmc_baud_div(3'd3) : rmc_baud_div(ctrl_reg[5:3]);
  assign take = HSEL_I && HREADY_I && HTRANS_I[1] && (HSIZE_I == 3'b010);

  rmc_uart u_uart (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .div_i(div),
    .rxd_i(LINK.dev_txd),
    .tx_data_i(tx_data_reg),
    .tx_start_i(tx_start_reg),
    .txd_o(LINK.host_txd),
    .tx_busy_o(tx_busy),
    .rx_data_o(rx_data),
    .rx_valid_o(rx_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdy_s1_reg <= 1'b0;
      rdy_s2_reg <= 1'b0;
      rdy_d_reg <= 1'b0;
      busy_d_reg <= 1'b0;
    end else begin
      rdy_s1_reg <= LINK.ready_status;
      rdy_s2_reg <= rdy_s1_reg;
      rdy_d_reg <= rdy_s2_reg;
      busy_d_reg <= tx_busy;
    end
  end
  // ready rising edge flagged to software
  assign ev = {rdy_s2_reg && !rdy_d_reg, busy_d_reg && !tx_busy, rx_valid};

  ////////////////////////////////////////////////////////////////////////
  // Zero wait states: reads are fetched in the address phase
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      HRDATA_O <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      wr_pend_reg <= take && HWRITE_I;
      wr_addr_reg <= HADDR_I[7:0];
      HRDATA_O <= 32'h0000_0000;
      if (take && !HWRITE_I) begin
        case (HADDR_I[7:0])
          `RMC_ADDR_CTRL: HRDATA_O <= {26'h000_0000, ctrl_reg};
          `RMC_ADDR_RXDATA: HRDATA_O <= {24'h00_0000, rx_reg};
          `RMC_ADDR_STATUS: HRDATA_O <= {22'h00_0000, tx_busy, rdy_s2_reg, 5'h00, status_reg};
          `RMC_ADDR_MASK: HRDATA_O <= {29'h0000_0000, mask_reg};
          default: HRDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // A write to transmit data while the UART is busy is dropped
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_reg <= {3'd3, RMC_MODE_SLEEP};
      mask_reg <= 3'b000;
      status_reg <= 3'b000;
      tx_start_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      rx_reg <= 8'h00;
      LINK.mode_select_0 <= 1'b1;
      LINK.mode_select_1 <= 1'b1;
      LINK.mode_select_2 <= 1'b1;
      IRQ_O <= 1'b0;
    end else begin
      tx_start_reg <= 1'b0;
      if (rx_valid) rx_reg <= rx_data;
      // Set wins over a clearing write in the same cycle
      if (wr_pend_reg && wr_addr_reg == `RMC_ADDR_STATUS) begin
        status_reg <= (status_reg & ~HWDATA_I[2:0]) | ev;
      end else begin
        status_reg <= status_reg | ev;
      end
      if (wr_pend_reg && wr_addr_reg == `RMC_ADDR_CTRL) ctrl_reg <= HWDATA_I[5:0];
      if (wr_pend_reg && wr_addr_reg == `RMC_ADDR_MASK) mask_reg <= HWDATA_I[2:0];
      if (wr_pend_reg && wr_addr_reg == `RMC_ADDR_TXDATA && !tx_busy && !tx_start_reg) begin
        tx_data_reg <= HWDATA_I[7:0];
        tx_start_reg <= 1'b1;
      end
      LINK.mode_select_0 <= ctrl_reg[0];
      LINK.mode_select_1 <= ctrl_reg[1];
      LINK.mode_select_2 <= ctrl_reg[2];
      IRQ_O <= |(status_reg & mask_reg);
    end
  end
endmodule
`default_nettype wire

// ===== tb/rmc_props.sv
// Link checks between host controller and radio module
`timescale 1ns/1ps
`default_nettype none
module rmc_props #(
  parameter int RECONF_CYC = 20
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic mode_select_0,
  input wire logic mode_select_1,
  input wire logic mode_select_2,
  input wire logic host_txd,
  input wire logic dev_txd,
  input wire logic ready_status
);
  // Slack for pin sync and apply stages
  localparam int MAXLOW = RECONF_CYC + 8;
  localparam int BIT = 20000000 / 9600;
  logic [2:0] pins;
  logic cfg;
  int dcnt;
  int hcnt;
  assign pins = {mode_select_2, mode_select_1, mode_select_0};
  assign cfg = (pins == 3'h5) || (pins == 3'h3);
  // Low-run lengths of both serial lines
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      dcnt <= 0;
      hcnt <= 0;
    end else begin
      dcnt <= dev_txd ? 0 : dcnt + 1;
      hcnt <= host_txd ? 0 : hcnt + 1;
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  pin_ready_a: assert property ($changed(pins) |-> ##[1:4] !ready_status)
    else $error("ready stayed high after pin change");
  cfg_exit_a: assert property ($past(cfg) && !cfg |-> ##4 !ready_status [*8])
    else $error("ready not held low on leaving configuration");
  ready_rise_a: assert property ($rose(ready_status) |-> pins == $past(pins, 8))
    else $error("ready rose while pins unsettled");
  low_bound_a: assert property ($fell(ready_status) |-> ##[1:MAXLOW] ready_status)
    else $error("reconfiguration too long");
  pwr_ready_a: assert property ($fell(RST_I) |-> !ready_status [*8])
    else $error("ready high too soon after power-up");
  sleep_idle_a: assert property ((pins == 3'h7) [*4] |-> dev_txd)
    else $error("module line active in sleep");
  // Low runs must be whole bit times at the configuration rate
  dev_bit_a: assert property ($rose(dev_txd) && cfg |-> (dcnt + 3) % BIT < 6)
    else $error("module bit time not configuration rate");
  host_bit_a: assert property ($rose(host_txd) && cfg |-> (hcnt + 3) % BIT < 6)
    else $error("host bit time not configuration rate");
  reply_after_a: assert property ($fell(dev_txd) && cfg |-> host_txd && $past(host_txd, 100))
    else $error("reply started during command");
  cover property ($rose(ready_status));
  cover property ($fell(dev_txd) && cfg);
  cover property ($past(cfg) && !cfg);
endmodule
`default_nettype wire

// ===== tb/test_radio_module_mode_and_config_cmd.sv
// Bench for host controller and radio module pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED at %0t got %h expected %h", $time, (a), (e)); end end
module test_radio_module_mode_and_config_cmd;
  logic clk, rst, hwrite, irq, hready;
  logic rfv, rfw, rfe;
  logic [7:0] rfb;
  logic [1:0] htrans;
  logic [2:0] hs;
  logic [4:0] st;
  logic [7:0] wlen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int miscompares, cmp_count;
  // Expected {mode, transmit, receive}
  logic [4:0] tbl [5] = '{5'h14, 5'h1C, 5'h12, 5'h19, 5'h0C};
  rmc_link_if link_i();
  rmc_dev #(.RECONF_CYC(20), .WOR_CYC(200), .LISTEN_CYC(20)) rmc_dev_i(.MCLK_I(clk),
    .RST_I(rst), .LINK(link_i.dev), .RF_BYTE_I(rfb), .RF_BYTE_VALID_I(rfv),
    .RF_PKT_WAKE_I(rfw), .RF_PKT_END_I(rfe), .RF_TX_EN_O(st[1]), .RF_RX_EN_O(st[0]),
    .WOR_LISTEN_O(), .RF_TX_DATA_O(), .RF_TX_VALID_O(), .WAKE_CODE_LEN_O(wlen),
    .NV_WRITE_O(), .MODE_O(st[4:2]));
  rmc_host rmc_host_i(.MCLK_I(clk), .RST_I(rst), .LINK(link_i.host), .HSEL_I(1'b1),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hs), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .IRQ_O(irq));
  rmc_props #(.RECONF_CYC(20)) rmc_props_i(.MCLK_I(clk), .RST_I(rst),
    .mode_select_0(link_i.mode_select_0), .mode_select_1(link_i.mode_select_1),
    .mode_select_2(link_i.mode_select_2), .host_txd(link_i.host_txd),
    .dev_txd(link_i.dev_txd), .ready_status(link_i.ready_status));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // No wait-count guess: a poll ends when the bit matches, or when the watchdog fires
  task automatic wait_bit(input int b, input logic v);
    do bus(32'h0000_000C, 1'b0, 32'h0); while (rd[b] !== v);
  endtask
  initial begin
    rst = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hs = 3'h2;
    {rfv, rfw, rfe} = 3'b000;
    rfb = 8'hFF;
    miscompares = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(32'h0000_0000, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_001F)
    bus(32'h0000_0020, 1'b1, 32'h0000_FFFF);
    bus(32'h0000_0020, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_0000)
    wait_bit(8, 1'b1);
    bus(32'h0000_0010, 1'b1, 32'h0000_0004);
    bus(32'h0000_000C, 1'b1, 32'h0000_0004);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      bus(32'h0000_0000, 1'b1, {26'h0, 3'h3, tbl[i][4:2]});
      repeat (6) @(posedge clk);
      wait_bit(8, 1'b1);
      // Interrupt flop lags the status flag by one edge
      repeat (2) @(posedge clk);
      `CHK(st, tbl[i])
      `CHK(wlen, (tbl[i][4:2] == 3'h4) ? 8'h40 : 8'h00)
      `CHK(irq, 1'b1)
      if (tbl[i][4:2] == 3'h6) begin
        rfv <= 1'b1;
        @(posedge clk);
        rfv <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(link_i.dev_txd, 1'b1)
        {rfv, rfw} <= 2'b11;
        @(posedge clk);
        {rfv, rfe} <= 2'b01;
        repeat (4) @(posedge clk);
        `CHK(link_i.dev_txd, 1'b0)
      end
      bus(32'h0000_000C, 1'b1, 32'h0000_0004);
    end
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    $display("mode test done");
    repeat (3) begin
      bus(32'h0000_0004, 1'b1, 32'h0000_00C1);
      repeat (2) @(posedge clk);
      wait_bit(9, 1'b0);
    end
    bus(32'h0000_0008, 1'b0, 32'h0);
    `CHK(rd[7:0], 8'hFF)
    bus(32'h0000_000C, 1'b1, 32'h0000_0001);
    wait_bit(0, 1'b1);
    bus(32'h0000_0008, 1'b0, 32'h0);
    `CHK(rd[7:0], 8'hC0)
    $display("command test done");
    close_out();
  end
  initial begin
    #5_000_000;
    miscompares++;
    $display("watchdog expired");
    close_out();
  end
endmodule
`default_nettype wire
